// >>> rss_pkg.sv
// package for the reset strap sequencer: timing counts, strap record types
// assumes a single 20 MHz host clock
package rss_pkg;

  // ==========================================================
  // clock and timing
  localparam int unsigned CLK_HZ          = 20_000_000;
  localparam int unsigned CPU_RST_DLY_US  = 1000;
  localparam int unsigned CPU_RST_DLY_CYC = CPU_RST_DLY_US * (CLK_HZ / 1_000_000);
  localparam int unsigned STRAP_LEAD_CLK  = 6;
  localparam int unsigned STRAP_LAG_CLK   = 4;
  localparam int unsigned FLOAT_HOLD_CLK  = 4;
  localparam int unsigned MAX_OUTSTANDING = 4;

  // ==========================================================
  // strap defaults (pin pull values when nothing is fitted)
  localparam logic QUEUE_DEPTH_MEM_DFLT = 1'b1;
  localparam logic QUICK_START_MEM_DFLT = 1'b1;
  localparam logic RESERVED_MEM_VALUE   = 1'b1;

  // ==========================================================
  // bridge_config_reg bit positions
  localparam int unsigned CFG_QUEUE_DEPTH_BIT = 2;
  localparam int unsigned CFG_RESERVED_BIT    = 13;
  localparam int unsigned CFG_WIDTH           = 16;

  typedef struct packed {
    logic reserved_mem;
    logic queue_depth_mem;
    logic quick_start_mem;
  } rss_straps_s;

  typedef struct packed {
    logic system_reset;
    logic cold_reset;
    logic suspend;
  } rss_power_s;

endpackage

// >>> rss_reset_strap_sequencer.sv
// reset strap sequencer: strap capture, processor reset timing, strap drive
// assumes pins pass through pad logic outside; enables high while driving
// What this block does
// R1: strap pins stay undriven during system reset and at least four clocks after it ends.
// R2: strap values are captured at system reset release into the configuration bits.
// R3: an unfitted strap reads back as its internal pull default.
// R4: controlled processor straps go active at least six clocks before processor reset releases.
// R5: controlled processor straps go inactive four clocks after processor reset releases.
// R6: the processor samples the quick-start strap at processor reset release.
// R7: the processor samples the queue-depth strap at release; asserted means depth one.
// R8: with maximum queue depth, outstanding bus transactions are held to four by block-next-request.
// R9: the reserved strap bit 13 is forced to one.
// R10: the system reset input pulldown is on in suspend and cold reset only.
// R11: host and pci clock pulldowns are on in cold reset and suspend only.
// R12: the memory clock feedback pulldown is on in suspend and cold reset.
// R13: processor reset is active whenever system reset is asserted.
// R14: processor reset releases 1 ms after system reset releases.
// R15: a zero queue-depth memory strap drives the queue-depth address strap low around release.
// R16: a one quick-start memory strap drives the quick-start address strap low around release.
// R17: straps latch on system reset release and hold until the next system reset.
module rss_reset_strap_sequencer
  import rss_pkg::*;
#(
  parameter int unsigned CPU_RST_CYC = CPU_RST_DLY_CYC
)(
  // clock and reset
  input  wire logic                 CLK,
  input  wire logic                 RESETN,
  // system state
  input  wire logic                 SYSTEM_RESET_N,
  input  wire logic                 COLD_RESET,
  input  wire logic                 SUSPEND,
  // strap pins (raw, asynchronous)
  input  wire logic                 QUEUE_DEPTH_MEM_STRAP,
  input  wire logic                 QUICK_START_MEM_STRAP,
  input  wire logic                 RESERVED_MEM_STRAP,
  output logic                      STRAP_PINS_OE,
  // processor bus
  output logic                      PROCESSOR_RESET_N,
  output logic                      QUEUE_DEPTH_ADDR_STRAP_O,
  output logic                      QUEUE_DEPTH_ADDR_STRAP_OE,
  output logic                      QUICK_START_ADDR_STRAP_O,
  output logic                      QUICK_START_ADDR_STRAP_OE,
  input  wire logic                 QUEUE_DEPTH_ADDR_STRAP_I,
  input  wire logic                 TXN_ISSUE,
  input  wire logic                 TXN_DONE,
  output logic                      BLOCK_NEXT_REQUEST_N,
  // configuration and pulldowns
  output logic [CFG_WIDTH-1:0]      BRIDGE_CONFIG_REG,
  output logic                      QUICK_START_CFG,
  output logic                      IN_ORDER_QUEUE_DEPTH_MAX,
  output logic                      SYSTEM_RESET_PULLDOWN,
  output logic                      CLOCK_PULLDOWN,
  output logic                      MEMORY_CLOCK_PULLDOWN
);

  // ==========================================================
  // synchronisers
  logic [1:0]  sysrst_sync;
  rss_straps_s strap_s1;
  rss_straps_s strap_s2;
  logic [1:0]  qd_addr_sync;
  logic [1:0]  cold_sync;
  logic [1:0]  susp_sync;

  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      sysrst_sync  <= 2'h0;
      strap_s1     <= '0;
      strap_s2     <= '0;
      qd_addr_sync <= 2'h3;
      cold_sync    <= 2'h3;
      susp_sync    <= 2'h0;
    end
    else
    begin
      sysrst_sync  <= {sysrst_sync[0], SYSTEM_RESET_N};
      strap_s1     <= '{RESERVED_MEM_STRAP, QUEUE_DEPTH_MEM_STRAP, QUICK_START_MEM_STRAP};
      strap_s2     <= strap_s1;
      qd_addr_sync <= {qd_addr_sync[0], QUEUE_DEPTH_ADDR_STRAP_I};
      cold_sync    <= {cold_sync[0], COLD_RESET};
      susp_sync    <= {susp_sync[0], SUSPEND};
    end
  end

  logic sys_rst;
  logic sys_rst_d;
  logic sys_rel;
  assign sys_rst = !sysrst_sync[1];
  assign sys_rel = sys_rst_d && !sys_rst;

  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
      sys_rst_d <= 1'h1;
    else
      sys_rst_d <= sys_rst;
  end

  // ==========================================================
  // strap capture; the pads' pulls give the default when unfitted
  rss_straps_s latched;

  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
      latched <= '{RESERVED_MEM_VALUE, QUEUE_DEPTH_MEM_DFLT, QUICK_START_MEM_DFLT}; // R3
    else if (sys_rel)
    begin
      latched.queue_depth_mem <= strap_s2.queue_depth_mem; // R2 R17
      latched.quick_start_mem <= strap_s2.quick_start_mem; // R2 R17
      latched.reserved_mem    <= RESERVED_MEM_VALUE;       // R9
    end
  end

  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
      BRIDGE_CONFIG_REG <= '0;
    else
    begin
      BRIDGE_CONFIG_REG                      <= '0;
      BRIDGE_CONFIG_REG[CFG_QUEUE_DEPTH_BIT] <= latched.queue_depth_mem; // R2
      BRIDGE_CONFIG_REG[CFG_RESERVED_BIT]    <= RESERVED_MEM_VALUE;      // R9
    end
  end

  // ==========================================================
  // processor reset timer: counts from system reset release
  localparam int unsigned CW = $clog2(CPU_RST_CYC + STRAP_LAG_CLK + 2);
  logic [CW-1:0] rel_cnt;
  logic          cpu_rst;
  logic [2:0]    lag_cnt;

  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      rel_cnt <= '0;
      cpu_rst <= 1'h1;
    end
    else if (sys_rst)
    begin
      rel_cnt <= '0;
      cpu_rst <= 1'h1; // R13
    end
    else if (cpu_rst)
    begin
      if (rel_cnt == CW'(CPU_RST_CYC - 1))
        cpu_rst <= 1'h0; // R14
      rel_cnt <= rel_cnt + CW'(1);
    end
  end

  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
      lag_cnt <= 3'h0;
    else if (cpu_rst)
      lag_cnt <= 3'h0;
    else if (lag_cnt != 3'(STRAP_LAG_CLK))
      lag_cnt <= lag_cnt + 3'h1; // R5
  end

  // drive window opens at least six clocks before release, never in system reset
  logic drive_win;
  assign drive_win = !sys_rst && !sys_rel && cpu_rst
                     && (rel_cnt >= CW'(FLOAT_HOLD_CLK))
                     && (rel_cnt <= CW'(CPU_RST_CYC - STRAP_LEAD_CLK)); // R1 R4

  logic drv_on;
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
      drv_on <= 1'h0;
    else if (sys_rst)
      drv_on <= 1'h0; // R1
    else if (drive_win)
      drv_on <= 1'h1; // R4
    else if (!cpu_rst && lag_cnt >= 3'(STRAP_LAG_CLK - 1))
      drv_on <= 1'h0; // R5
  end

  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      PROCESSOR_RESET_N         <= 1'h0;
      QUEUE_DEPTH_ADDR_STRAP_OE <= 1'h0;
      QUICK_START_ADDR_STRAP_OE <= 1'h0;
      QUEUE_DEPTH_ADDR_STRAP_O  <= 1'h1;
      QUICK_START_ADDR_STRAP_O  <= 1'h1;
      STRAP_PINS_OE             <= 1'h0;
    end
    else
    begin
      PROCESSOR_RESET_N         <= !cpu_rst && !sys_rst;                             // R13
      QUEUE_DEPTH_ADDR_STRAP_OE <= drv_on && !sys_rst && !latched.queue_depth_mem; // R15
      QUICK_START_ADDR_STRAP_OE <= drv_on && !sys_rst && latched.quick_start_mem;  // R16
      QUEUE_DEPTH_ADDR_STRAP_O  <= 1'h0;
      QUICK_START_ADDR_STRAP_O  <= 1'h0;
      // memory strap pins return only after the float hold
      STRAP_PINS_OE             <= !sys_rst && (rel_cnt >= CW'(FLOAT_HOLD_CLK) || !cpu_rst); // R1
    end
  end

  // ==========================================================
  // queue-depth readback at processor reset release
  logic cpu_rst_d;
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      cpu_rst_d                <= 1'h1;
      IN_ORDER_QUEUE_DEPTH_MAX <= 1'h0;
      QUICK_START_CFG          <= 1'h0;
    end
    else
    begin
      cpu_rst_d <= cpu_rst;
      if (cpu_rst_d && !cpu_rst)
      begin
        // low on the active-low line means depth one
        IN_ORDER_QUEUE_DEPTH_MAX <= qd_addr_sync[1];          // R7
        QUICK_START_CFG          <= latched.quick_start_mem;  // R6
      end
    end
  end

  // ==========================================================
  // pipeline throttle
  logic [3:0] outstanding;
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
      outstanding <= 4'h0;
    else if (cpu_rst)
      outstanding <= 4'h0;
    else
      outstanding <= outstanding + 4'(TXN_ISSUE) - 4'(TXN_DONE && outstanding != 4'h0);
  end

  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
      BLOCK_NEXT_REQUEST_N <= 1'h1;
    else
      BLOCK_NEXT_REQUEST_N <= !(IN_ORDER_QUEUE_DEPTH_MAX
                               && (outstanding + 4'(TXN_ISSUE) >= 4'(MAX_OUTSTANDING))); // R8
  end

  // ==========================================================
  // pulldowns
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      SYSTEM_RESET_PULLDOWN <= 1'h1;
      CLOCK_PULLDOWN        <= 1'h1;
      MEMORY_CLOCK_PULLDOWN <= 1'h1;
    end
    else
    begin
      SYSTEM_RESET_PULLDOWN <= cold_sync[1] || susp_sync[1]; // R10
      CLOCK_PULLDOWN        <= cold_sync[1] || susp_sync[1]; // R11
      MEMORY_CLOCK_PULLDOWN <= cold_sync[1] || susp_sync[1]; // R12
    end
  end

  // ==========================================================
  // checks
  sequence s_release;
    cpu_rst_d && !cpu_rst;
  endsequence

  a_cpu_in_sysrst: assert property (@(posedge CLK) disable iff (!RESETN) // R13
    sys_rst |=> !PROCESSOR_RESET_N) else $error("processor reset released in system reset");
  a_float_in_rst: assert property (@(posedge CLK) disable iff (!RESETN) // R1
    sys_rst |=> !QUEUE_DEPTH_ADDR_STRAP_OE && !QUICK_START_ADDR_STRAP_OE && !STRAP_PINS_OE)
    else $error("strap pin driven in system reset");
  a_strap_lag_end: assert property (@(posedge CLK) disable iff (!RESETN) // R5
    $rose(PROCESSOR_RESET_N) |-> ##(STRAP_LAG_CLK) !QUEUE_DEPTH_ADDR_STRAP_OE && !QUICK_START_ADDR_STRAP_OE)
    else $error("strap drive did not end after lag");
  a_strap_lead: assert property (@(posedge CLK) disable iff (!RESETN) // R4 R16
    s_release ##0 latched.quick_start_mem |-> $past(QUICK_START_ADDR_STRAP_OE, STRAP_LEAD_CLK - 1))
    else $error("quick start strap not driven early enough");
  a_qd_strap_off: assert property (@(posedge CLK) disable iff (!RESETN) // R15
    latched.queue_depth_mem |=> !QUEUE_DEPTH_ADDR_STRAP_OE) else $error("queue depth strap driven wrongly");
  a_reserved_bit: assert property (@(posedge CLK) disable iff (!RESETN) // R9
    1'b1 |=> BRIDGE_CONFIG_REG[CFG_RESERVED_BIT]) else $error("reserved bit not one");
  a_latch_hold: assert property (@(posedge CLK) disable iff (!RESETN) // R17
    !sys_rst && !sys_rel |=> $stable(latched)) else $error("straps changed outside reset");
  a_throttle: assert property (@(posedge CLK) disable iff (!RESETN) // R8
    IN_ORDER_QUEUE_DEPTH_MAX && outstanding >= 4'(MAX_OUTSTANDING) |=> !BLOCK_NEXT_REQUEST_N)
    else $error("throttle missed at four outstanding");
  a_pulldowns: assert property (@(posedge CLK) disable iff (!RESETN) // R10 R11 R12
    (cold_sync[1] || susp_sync[1]) |=> SYSTEM_RESET_PULLDOWN && CLOCK_PULLDOWN && MEMORY_CLOCK_PULLDOWN)
    else $error("pulldown not enabled");

endmodule

// >>> rss_host_cpu_model.sv
// host processor model: samples the address straps at processor reset release
// assumes termination pulls an undriven address line high (deasserted)
module rss_host_cpu_model (
  // processor reset from the bridge
  input  wire logic cpu_reset_n,
  // address strap drive from the bridge
  input  wire logic qd_o,
  input  wire logic qd_oe,
  input  wire logic qs_o,
  input  wire logic qs_oe,
  // line levels and sampled modes
  output logic      qd_line,
  output logic      qs_line,
  output logic      in_order_queue_depth_one,
  output logic      quick_start_en
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // line levels: released lines float up to the pull level
  assign qd_line = qd_oe ? qd_o : 1'b1;
  assign qs_line = qs_oe ? qs_o : 1'b1;

  // ==========================================================
  // strap sampling, active-low lines
  always @(posedge cpu_reset_n)
  begin
    in_order_queue_depth_one       <= !qd_line;
    quick_start_en <= !qs_line;
  end
endmodule

// >>> tb.sv
// testbench for the reset strap sequencer: boots, throttle, pulldowns
// assumes the host cpu model supplies the queue-depth line level
module tb
  import rss_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // signals
  localparam int CPU_RST = 40;
  logic                 clk;
  logic                 resetn;
  logic                 sys_rst_n;
  logic                 cold;
  logic                 susp;
  logic                 issue;
  logic                 done;
  rss_straps_s          strap;
  logic                 pins_oe;
  logic                 cpu_rst_n;
  logic                 qd_o;
  logic                 qd_oe;
  logic                 qs_o;
  logic                 qs_oe;
  logic                 qd_line;
  logic                 qs_line;
  logic                 bnr_n;
  logic                 qs_cfg;
  logic                 in_order_queue_depth_max;
  logic                 sr_pd;
  logic                 clk_pd;
  logic                 mclk_pd;
  logic                 in_order_queue_depth_one;
  logic                 qs_en;
  logic [CFG_WIDTH-1:0] cfg;
  int                   mismatches;
  int                   tests_run;
  // straps: reserved, queue depth, quick start; 3'h7 is all unfitted
  rss_straps_s          tbl [4] = '{3'h7, 3'h2, 3'h5, 3'h0};

  rss_reset_strap_sequencer #(.CPU_RST_CYC(CPU_RST)) dut_u (
    .CLK(clk), .RESETN(resetn), .SYSTEM_RESET_N(sys_rst_n),
    .COLD_RESET(cold), .SUSPEND(susp),
    .QUEUE_DEPTH_MEM_STRAP(strap.queue_depth_mem),
    .QUICK_START_MEM_STRAP(strap.quick_start_mem),
    .RESERVED_MEM_STRAP(strap.reserved_mem), .STRAP_PINS_OE(pins_oe),
    .PROCESSOR_RESET_N(cpu_rst_n),
    .QUEUE_DEPTH_ADDR_STRAP_O(qd_o), .QUEUE_DEPTH_ADDR_STRAP_OE(qd_oe),
    .QUICK_START_ADDR_STRAP_O(qs_o), .QUICK_START_ADDR_STRAP_OE(qs_oe),
    .QUEUE_DEPTH_ADDR_STRAP_I(qd_line), .TXN_ISSUE(issue), .TXN_DONE(done),
    .BLOCK_NEXT_REQUEST_N(bnr_n), .BRIDGE_CONFIG_REG(cfg),
    .QUICK_START_CFG(qs_cfg), .IN_ORDER_QUEUE_DEPTH_MAX(in_order_queue_depth_max),
    .SYSTEM_RESET_PULLDOWN(sr_pd), .CLOCK_PULLDOWN(clk_pd),
    .MEMORY_CLOCK_PULLDOWN(mclk_pd)
  );

  rss_host_cpu_model cpu_u (
    .cpu_reset_n(cpu_rst_n), .qd_o(qd_o), .qd_oe(qd_oe), .qs_o(qs_o),
    .qs_oe(qs_oe), .qd_line(qd_line), .qs_line(qs_line),
    .in_order_queue_depth_one(in_order_queue_depth_one), .quick_start_en(qs_en)
  );

  // ==========================================================
  // clock, watchdog, reporting
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // four boots of about 60 cycles plus throttle and pulldowns
  initial
  begin
    repeat (5000) @(posedge clk);
    mismatches++;
    finish_test();
  end

  task automatic finish_test();
    if (mismatches == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // ==========================================================
  // one system reset with the given straps
  task automatic boot(input rss_straps_s s);
    int          n = 0;
    int          lead = 0;
    int          lag = 0;
    logic        qd_seen = 1'b0;
    logic        qs_seen = 1'b0;
    logic        drv = !s.queue_depth_mem || s.quick_start_mem;
    logic [15:0] exp_cfg = '0;
    exp_cfg[CFG_RESERVED_BIT] = 1'b1;
    exp_cfg[CFG_QUEUE_DEPTH_BIT] = s.queue_depth_mem;
    @(posedge clk);
    sys_rst_n <= 1'b0;
    strap <= s;
    repeat (6) @(posedge clk);
    @(negedge clk);
    check("cpu_rst_n", cpu_rst_n, 1'b0);
    check("pins_oe", pins_oe, 1'b0);
    @(posedge clk);
    sys_rst_n <= 1'b1;
    while (cpu_rst_n !== 1'b1 && n < 200)
    begin
      @(negedge clk);
      n++;
      if (n <= 4)
        check("pins_oe late", pins_oe, 1'b0);
      qd_seen |= qd_oe;
      qs_seen |= qs_oe;
      if (cpu_rst_n === 1'b0 && (qd_oe || qs_oe))
        lead++;
    end
    // sync stages add a few cycles to the release delay
    check("release delay", n >= CPU_RST && n <= CPU_RST + 8, 1'b1);
    check("pins_oe on", pins_oe, 1'b1);
    while ((qd_oe || qs_oe) && lag < 20)
    begin
      lag++;
      @(negedge clk);
    end
    check("strap lead", lead >= 6, drv);
    // drive ends four clocks after the processor reset output rises
    check("strap lag", lag == STRAP_LAG_CLK, drv);
    check("qd drive", qd_seen, !s.queue_depth_mem);
    check("qs drive", qs_seen, s.quick_start_mem);
    check("cpu depth one", in_order_queue_depth_one, !s.queue_depth_mem);
    check("cpu quick start", qs_en, s.quick_start_mem);
    check("config", cfg, exp_cfg);
    check("depth max", in_order_queue_depth_max, s.queue_depth_mem);
    check("quick cfg", qs_cfg, s.quick_start_mem);
    @(posedge clk);
    strap <= ~s;
    repeat (6) @(posedge clk);
    @(negedge clk);
    check("config held", cfg, exp_cfg);
    check("quick cfg held", qs_cfg, s.quick_start_mem);
  endtask

  task automatic throttle(input logic max_depth);
    @(posedge clk);
    issue <= 1'b1;
    repeat (4) @(posedge clk);
    issue <= 1'b0;
    @(negedge clk);
    check("bnr four", bnr_n, !max_depth);
    @(posedge clk);
    done <= 1'b1;
    @(posedge clk);
    done <= 1'b0;
    // the count drops at this edge, the registered throttle one edge later
    @(posedge clk);
    @(negedge clk);
    check("bnr three", bnr_n, 1'b1);
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    resetn = 1'b0;
    sys_rst_n = 1'b0;
    cold = 1'b0;
    susp = 1'b0;
    issue = 1'b0;
    done = 1'b0;
    strap = '1;
    mismatches = 0;
    tests_run = 0;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      boot(tbl[i]);
      throttle(tbl[i].queue_depth_mem);
    end
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk);
      cold <= i[0];
      susp <= i[1];
      repeat (4) @(posedge clk);
      @(negedge clk);
      check("rst pulldown", sr_pd, i[0] | i[1]);
      check("clk pulldown", clk_pd, i[0] | i[1]);
      check("mclk pulldown", mclk_pd, i[0] | i[1]);
    end
    finish_test();
  end
endmodule
